// [ifep_regs.svh]
// Register offsets, field positions and reset values of the interrupt controller
`ifndef IFEP_REGS_SVH
`define IFEP_REGS_SVH
`define IFEP_ADDR_W 5
`define IFEP_DATA_W 16
`define IFEP_NSRC 64
`define IFEP_OFF_CTL1 5'h00
`define IFEP_OFF_CTL2 5'h01
`define IFEP_OFF_FLAG0 5'h02
`define IFEP_OFF_EN0 5'h06
`define IFEP_OFF_PRI0 5'h0a
`define IFEP_OFF_TRAP 5'h1a
`define IFEP_OFF_SR 5'h1b
`define IFEP_OFF_CORE 5'h1c
`define IFEP_OFF_IST 5'h1d
`define IFEP_OFF_ICLR 5'h1e
`define IFEP_OFF_IEN 5'h1f
`define IFEP_FLAG_REGS 4
`define IFEP_PRI_REGS 16
`define IFEP_NTRAP 5
`define IFEP_NEST_BIT 15
`define IFEP_ALTERNATE_VECTOR_TABLE_BIT 15
`define IFEP_NEXT 3
`define IFEP_SR_LO 5
`define IFEP_SR_HI 7
`define IFEP_CORE_CPU_PRIORITY_TOP_BIT 3
`define IFEP_TRAP_LVL_LO 8
`define IFEP_PRI_W 3
`define IFEP_VEC_W 7
`define IFEP_LVL_W 4
`define IFEP_TRAP_LEVEL 4'h8
`define IFEP_RST_PRI 16'h4444
`define IFEP_RST_FIELD 3'h4
`define IFEP_NEV 3
`endif

// [ifep_pkg.sv]
// Types shared by the interrupt controller files
package ifep_pkg;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [15:0] wdata;
   } ifep_bus_t;
   typedef struct packed {
      logic valid;
      logic [6:0] vector;
      logic [3:0] level;
   } ifep_pend_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_TAKEN = 3'b010,
      ST_WAIT = 3'b100
   } ifep_state_t;
endpackage

// [ifep_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module ifep_sync (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic din,
   output logic dout
);
   logic s1_reg, s2_reg, s3_reg, out_reg;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         out_reg <= 1'b0;
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            out_reg <= s3_reg;
         end
      end
   end
   assign dout = out_reg;
endmodule

// [ifep_arb.sv]
// Priority arbiter: picks the highest eligible source above the CPU level
`include "ifep_regs.svh"
`timescale 1ns/100ps
module ifep_arb (
   input wire logic [`IFEP_NSRC-1:0] flags,
   input wire logic [`IFEP_NSRC-1:0] enables,
   input wire logic [`IFEP_NSRC*`IFEP_PRI_W-1:0] prios,
   input wire logic [`IFEP_LVL_W-1:0] cpu_level,
   output ifep_pkg::ifep_pend_t pend
);
   import ifep_pkg::*;
   always_comb begin
      logic [`IFEP_LVL_W-1:0] lvl;
      pend = '0;
      lvl = '0;
      // Lowest vector wins ties (natural order)
      for (int i = `IFEP_NSRC - 1; i >= 0; i--) begin
         lvl = {1'b0, prios[i*`IFEP_PRI_W +: `IFEP_PRI_W]};
         if (flags[i] && enables[i] && lvl > cpu_level && lvl >= pend.level) begin
            pend.valid = 1'b1;
            pend.vector = 7'(i);
            pend.level = lvl;
         end
      end
   end
endmodule

// [ifep_top.sv]
// Interrupt flag, enable and priority controller top level
//
// Our own choices: the register offsets and the address-and-strobe port.
`include "ifep_regs.svh"
`timescale 1ns/100ps
module ifep_top (
   input wire logic clk_sys,
   input wire logic srst,
   input wire ifep_pkg::ifep_bus_t bus,
   output logic [15:0] rdata,
   input wire logic [`IFEP_NSRC-1:0] periph_req,
   input wire logic [`IFEP_NEXT-1:0] ext_req_pin,
   input wire logic [`IFEP_NTRAP-1:0] trap_event,
   input wire logic irq_ack,
   input wire logic irq_return,
   output logic cpu_irq,
   output logic [6:0] cpu_vector,
   output logic [3:0] cpu_level_out,
   output logic alternate_vector_table,
   output logic irq_out
);
   import ifep_pkg::*;
   // Control one: nesting disable and trap status flags
   logic [15:0] irq_control_one_reg;
   logic [15:0] irq_control_two_reg;
   logic [`IFEP_NSRC-1:0] request_flag_regs;
   logic [`IFEP_NSRC-1:0] source_enable_regs;
   logic [`IFEP_NSRC*`IFEP_PRI_W-1:0] source_priority_regs;
   logic [15:0] vector_trap_reg;
   logic [2:0] cpu_priority_level_reg;
   logic cpu_priority_top_bit_reg;
   logic [3:0] saved_level_reg;
   logic [`IFEP_NEV-1:0] ev_status_reg, ev_enable_reg;
   ifep_state_t state_reg, state_next;
   logic [`IFEP_NEXT-1:0] ext_sync, ext_prev_reg, ext_edge;
   logic [`IFEP_NSRC-1:0] hw_set;
   ifep_pend_t pend;
   logic [3:0] cpu_level;
   logic [15:0] rd_word;
   logic [`IFEP_NEV-1:0] ev_set;
   logic trap_any, take;

   genvar g;
   generate
      for (g = 0; g < `IFEP_NEXT; g++) begin : g_ext
         ifep_sync u_sync (
            .clk_sys(clk_sys),
            .srst(srst),
            .din(ext_req_pin[g]),
            .dout(ext_sync[g])
         );
         // Edge polarity per line from control two
         assign ext_edge[g] = irq_control_two_reg[g] ? (ext_prev_reg[g] & ~ext_sync[g])
                                                     : (~ext_prev_reg[g] & ext_sync[g]);
      end
   endgenerate

   // External request zero sits at vector 0, bit 0
   assign hw_set = periph_req | {{(`IFEP_NSRC-`IFEP_NEXT){1'b0}}, ext_edge};
   assign cpu_level = {cpu_priority_top_bit_reg, cpu_priority_level_reg};
   assign trap_any = |trap_event;

   ifep_arb u_arb (
      .flags(request_flag_regs),
      .enables(source_enable_regs),
      .prios(source_priority_regs),
      .cpu_level(cpu_level),
      .pend(pend)
   );

   // Nesting disable blocks new requests while one is in service
   assign take = pend.valid && !(irq_control_one_reg[`IFEP_NEST_BIT] && state_reg == ST_WAIT);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (take) begin
               state_next = ST_TAKEN;
            end
         end
         ST_TAKEN: begin
            if (irq_ack) begin
               state_next = ST_WAIT;
            end else if (!pend.valid) begin
               state_next = ST_IDLE;
            end
         end
         ST_WAIT: begin
            if (irq_return) begin
               state_next = ST_IDLE;
            end else if (take) begin
               state_next = ST_TAKEN;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   wire wr_ctl1 = bus.wr && bus.addr == `IFEP_OFF_CTL1;
   wire wr_ctl2 = bus.wr && bus.addr == `IFEP_OFF_CTL2;
   wire wr_sr = bus.wr && bus.addr == `IFEP_OFF_SR;
   wire wr_iclr = bus.wr && bus.addr == `IFEP_OFF_ICLR;
   wire wr_ien = bus.wr && bus.addr == `IFEP_OFF_IEN;
   wire wr_flag = bus.wr && bus.addr >= `IFEP_OFF_FLAG0 && bus.addr < `IFEP_OFF_EN0;
   wire wr_en = bus.wr && bus.addr >= `IFEP_OFF_EN0 && bus.addr < `IFEP_OFF_PRI0;
   wire wr_pri = bus.wr && bus.addr >= `IFEP_OFF_PRI0 && bus.addr < `IFEP_OFF_TRAP;
   wire [1:0] flag_idx = 2'(bus.addr - `IFEP_OFF_FLAG0);
   wire [1:0] en_idx = 2'(bus.addr - `IFEP_OFF_EN0);
   wire [3:0] pri_idx = 4'(bus.addr - `IFEP_OFF_PRI0);

   // Events: trap, request taken, external edge
   assign ev_set = {|ext_edge, state_reg == ST_IDLE && take, trap_any};

   // Request flags: hardware set wins over a software clear
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         request_flag_regs <= '0;
         source_enable_regs <= '0;
      end else begin
         for (int i = 0; i < `IFEP_NSRC; i++) begin
            if (hw_set[i]) begin
               request_flag_regs[i] <= 1'b1;
            end else if (wr_flag && flag_idx == 2'(i / 16)) begin
               request_flag_regs[i] <= bus.wdata[i % 16] & request_flag_regs[i];
            end
            if (wr_en && en_idx == 2'(i / 16)) begin
               source_enable_regs[i] <= bus.wdata[i % 16];
            end
         end
      end
   end

   // Four priority fields per word, lowest vector in bits 2:0
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int p = 0; p < `IFEP_PRI_REGS; p++) begin
            for (int f = 0; f < 4; f++) begin
               source_priority_regs[(p*4+f)*`IFEP_PRI_W +: `IFEP_PRI_W] <= `IFEP_RST_FIELD;
            end
         end
      end else if (wr_pri) begin
         for (int f = 0; f < 4; f++) begin
            source_priority_regs[(pri_idx*4+f)*`IFEP_PRI_W +: `IFEP_PRI_W] <= bus.wdata[f*4 +: `IFEP_PRI_W];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irq_control_one_reg <= '0;
         irq_control_two_reg <= '0;
         ev_status_reg <= '0;
         ev_enable_reg <= '0;
         ext_prev_reg <= '0;
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
         ext_prev_reg <= ext_sync;
         if (wr_ctl1) begin
            irq_control_one_reg[`IFEP_NEST_BIT] <= bus.wdata[`IFEP_NEST_BIT];
         end
         for (int t = 0; t < `IFEP_NTRAP; t++) begin
            if (trap_event[t]) begin
               irq_control_one_reg[t] <= 1'b1;
            end else if (wr_ctl1) begin
               irq_control_one_reg[t] <= bus.wdata[t] & irq_control_one_reg[t];
            end
         end
         if (wr_ctl2) begin
            irq_control_two_reg <= bus.wdata;
         end
         if (wr_ien) begin
            ev_enable_reg <= bus.wdata[`IFEP_NEV-1:0];
         end
         ev_status_reg <= ev_set | (ev_status_reg & ~({`IFEP_NEV{wr_iclr}} & bus.wdata[`IFEP_NEV-1:0]));
      end
   end

   // CPU level: software writes low three bits, top bit set by traps and restored from the saved level on return
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cpu_priority_level_reg <= '0;
         cpu_priority_top_bit_reg <= 1'b0;
         saved_level_reg <= '0;
         vector_trap_reg <= '0;
      end else begin
         if (trap_any) begin
            cpu_priority_top_bit_reg <= 1'b1;
         end else if (irq_return && state_reg == ST_WAIT) begin
            {cpu_priority_top_bit_reg, cpu_priority_level_reg} <= saved_level_reg;
         end else if (irq_ack && state_reg == ST_TAKEN) begin
            saved_level_reg <= cpu_level;
            cpu_priority_level_reg <= vector_trap_reg[`IFEP_TRAP_LVL_LO +: 3];
         end else if (wr_sr) begin
            cpu_priority_level_reg <= bus.wdata[`IFEP_SR_HI:`IFEP_SR_LO];
         end
         if (take && state_next == ST_TAKEN) begin
            vector_trap_reg <= {4'h0, pend.level, 1'b0, pend.vector};
         end
      end
   end

   // Read decode in the strobe cycle, registered so data stand in the next cycle only
   assign rd_word = (bus.addr == `IFEP_OFF_CTL1) ? irq_control_one_reg :
                    (bus.addr == `IFEP_OFF_CTL2) ? irq_control_two_reg :
                    (bus.addr >= `IFEP_OFF_FLAG0 && bus.addr < `IFEP_OFF_EN0) ?
                       request_flag_regs[16*flag_idx +: 16] :
                    (bus.addr >= `IFEP_OFF_EN0 && bus.addr < `IFEP_OFF_PRI0) ?
                       source_enable_regs[16*en_idx +: 16] :
                    (bus.addr >= `IFEP_OFF_PRI0 && bus.addr < `IFEP_OFF_TRAP) ?
                       {1'b0, source_priority_regs[12*pri_idx + 9 +: 3],
                        1'b0, source_priority_regs[12*pri_idx + 6 +: 3],
                        1'b0, source_priority_regs[12*pri_idx + 3 +: 3],
                        1'b0, source_priority_regs[12*pri_idx +: 3]} :
                    (bus.addr == `IFEP_OFF_TRAP) ? vector_trap_reg :
                    (bus.addr == `IFEP_OFF_SR) ? {8'h00, cpu_priority_level_reg, 5'h00} :
                    (bus.addr == `IFEP_OFF_CORE) ? {12'h000, cpu_priority_top_bit_reg, 3'h0} :
                    (bus.addr == `IFEP_OFF_IST) ? {13'h0, ev_status_reg} :
                    (bus.addr == `IFEP_OFF_IEN) ? {13'h0, ev_enable_reg} :
                    16'h0000;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rdata <= '0;
      end else begin
         rdata <= bus.rd ? rd_word : 16'h0000;
      end
   end

   assign cpu_irq = state_reg == ST_TAKEN;
   assign cpu_vector = vector_trap_reg[6:0];
   assign cpu_level_out = cpu_level;
   assign alternate_vector_table = irq_control_two_reg[`IFEP_ALTERNATE_VECTOR_TABLE_BIT];
   assign irq_out = |(ev_status_reg & ev_enable_reg);
endmodule

// [ifep_cpu.sv]
// Behavioural CPU core partner: acknowledges requests and returns after service
`timescale 1ns/100ps
module ifep_cpu #(parameter int RET = 12) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic cpu_irq,
   output logic irq_ack,
   output logic irq_return
);
   logic [4:0] cnt_reg;
   logic busy_reg;
   always_ff @(posedge clk_sys) begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      if (srst) begin
         busy_reg <= 1'b0;
         cnt_reg <= 5'h00;
      end else if (!busy_reg && cpu_irq && !irq_ack) begin
         irq_ack <= 1'b1;
         busy_reg <= 1'b1;
         cnt_reg <= 5'(RET);
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg - 5'h01;
         if (cnt_reg == 5'h01) begin
            irq_return <= 1'b1;
            busy_reg <= 1'b0;
         end
      end
   end
endmodule

// [ifep_chk.sv]
// Port-level assertions for the interrupt controller top
`include "ifep_regs.svh"
`timescale 1ns/100ps
module ifep_chk (
   input wire logic clk_sys,
   input wire logic srst,
   input wire ifep_pkg::ifep_bus_t bus,
   input wire logic [15:0] rdata,
   input wire logic [`IFEP_NSRC-1:0] periph_req,
   input wire logic [`IFEP_NEXT-1:0] ext_req_pin,
   input wire logic [`IFEP_NTRAP-1:0] trap_event,
   input wire logic irq_ack,
   input wire logic irq_return,
   input wire logic cpu_irq,
   input wire logic [6:0] cpu_vector,
   input wire logic [3:0] cpu_level_out,
   input wire logic alternate_vector_table,
   input wire logic irq_out
);
   import ifep_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   logic calm;
   assign calm = !irq_ack && !irq_return && (trap_event == 5'h00);
   property p_sr_write;
      bus.wr && bus.addr == 5'h1b && calm |=> cpu_level_out[2:0] == $past(bus.wdata[7:5]);
   endproperty
   a_sr_write: assert property (p_sr_write) else $error("status level write lost");
   property p_sr_read;
      bus.rd && bus.addr == 5'h1b && calm |=> rdata[7:5] == cpu_level_out[2:0];
   endproperty
   a_sr_read: assert property (p_sr_read) else $error("status level read wrong");
   property p_trap_top;
      trap_event != 5'h00 && !irq_return |=> cpu_level_out[3];
   endproperty
   a_trap_top: assert property (p_trap_top) else $error("trap did not raise top level bit");
   property p_core_ro;
      bus.wr && bus.addr == 5'h1c && calm |=> $stable(cpu_level_out[3]);
   endproperty
   a_core_ro: assert property (p_core_ro) else $error("top level bit written by software");
   property p_core_read;
      bus.rd && bus.addr == 5'h1c && calm |=> rdata[3] == cpu_level_out[3];
   endproperty
   a_core_read: assert property (p_core_read) else $error("top level bit read wrong");
   property p_avt;
      bus.wr && bus.addr == 5'h01 |=> alternate_vector_table == $past(bus.wdata[15]);
   endproperty
   a_avt: assert property (p_avt) else $error("alternate table select wrong");
   property p_irq_hold;
      cpu_irq && !irq_ack |=> cpu_irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("request dropped before ack");
   property p_irq_drop;
      cpu_irq && irq_ack |=> !cpu_irq;
   endproperty
   a_irq_drop: assert property (p_irq_drop) else $error("request stayed after ack");
   property p_rose_level;
      $rose(cpu_irq) |-> !$past(cpu_level_out[3]);
   endproperty
   a_rose_level: assert property (p_rose_level) else $error("request above trap level");
   c_ack: cover property (cpu_irq && irq_ack);
   c_trap: cover property (trap_event != 5'h00);
   c_irq_out: cover property ($rose(irq_out));
endmodule
bind ifep_top ifep_chk u_ifep_chk (.*);

// [tb_top.sv]
// Self-checking testbench for the interrupt controller
`include "ifep_regs.svh"
`timescale 1ns/100ps
module tb_top;
   import ifep_pkg::*;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   ifep_bus_t bus = '0;
   logic [15:0] rdata;
   logic [63:0] periph_req = '0;
   logic [2:0] ext_req_pin = '0;
   logic [4:0] trap_event = '0;
   logic irq_ack, irq_return, cpu_irq, alternate_vector_table, irq_out;
   logic [6:0] cpu_vector;
   logic [3:0] cpu_level_out;
   int fail_count = 0;
   int checked = 0;
   int cyc = 0;
   ifep_top u_ifep_top (.clk_sys(clk_sys), .srst(srst), .bus(bus), .rdata(rdata), .periph_req(periph_req),
      .ext_req_pin(ext_req_pin), .trap_event(trap_event), .irq_ack(irq_ack), .irq_return(irq_return),
      .cpu_irq(cpu_irq), .cpu_vector(cpu_vector), .cpu_level_out(cpu_level_out),
      .alternate_vector_table(alternate_vector_table), .irq_out(irq_out));
   ifep_cpu #(.RET(12)) u_ifep_cpu (.clk_sys(clk_sys), .srst(srst), .cpu_irq(cpu_irq), .irq_ack(irq_ack),
      .irq_return(irq_return));
   initial begin
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge clk_sys);
      bus <= '0;
      #1;
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] v);
      @(posedge clk_sys);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clk_sys);
      bus <= '0;
      #1 v = rdata;
   endtask
   task automatic rd_chk(input string name, input logic [4:0] a, input logic [15:0] mask, input logic [15:0] exp);
      logic [15:0] v;
      rd(a, v);
      chk(name, v & mask, exp);
   endtask
   task automatic pulse_src(input int n);
      @(posedge clk_sys);
      periph_req[n] <= 1'b1;
      @(posedge clk_sys);
      periph_req[n] <= 1'b0;
   endtask
   task automatic t_reset;
      rd_chk("ctl1", 5'h00, 16'hffff, 16'h0000);
      rd_chk("pri0", 5'h0a, 16'hffff, `IFEP_RST_PRI);
      rd_chk("sr", 5'h1b, 16'hffff, 16'h0000);
      wr(5'h00, 16'h8000);
      rd_chk("nest", 5'h00, 16'hffff, 16'h8000);
      $display("t_reset done");
   endtask
   task automatic t_flags;
      pulse_src(5);
      rd_chk("flag5", 5'h02, 16'hffff, 16'h0020);
      repeat (4) @(posedge clk_sys);
      chk("no_en", {15'h0, cpu_irq}, 16'h0000);
      wr(5'h02, 16'h0000);
      rd_chk("flag_clr", 5'h02, 16'hffff, 16'h0000);
      $display("t_flags done");
   endtask
   task automatic t_request;
      wr(5'h0b, 16'h4464);
      wr(5'h06, 16'h0020);
      wr(5'h1b, 16'h00c0);
      pulse_src(5);
      repeat (4) @(posedge clk_sys);
      chk("equal_lvl", {15'h0, cpu_irq}, 16'h0000);
      wr(5'h1b, 16'h00a0);
      for (int i = 0; i < 20 && irq_ack !== 1'b1; i++) begin
         @(negedge clk_sys);
      end
      chk("ack", {15'h0, irq_ack}, 16'h0001);
      wr(5'h02, 16'h0000);
      rd_chk("trap_reg", 5'h1a, 16'hffff, 16'h0605);
      chk("vec", {9'h0, cpu_vector}, 16'h0005);
      for (int i = 0; i < 30 && irq_return !== 1'b1; i++) begin
         @(negedge clk_sys);
      end
      repeat (2) @(posedge clk_sys);
      chk("lvl_back", {12'h0, cpu_level_out}, 16'h0005);
      $display("t_request done");
   endtask
   task automatic t_ext;
      wr(5'h01, 16'h8000);
      chk("avt", {15'h0, alternate_vector_table}, 16'h0001);
      @(posedge clk_sys);
      ext_req_pin <= 3'h1;
      repeat (8) @(posedge clk_sys);
      rd_chk("ext_flag", 5'h02, 16'h0001, 16'h0001);
      @(posedge clk_sys);
      ext_req_pin <= 3'h0;
      wr(5'h02, 16'h0000);
      wr(5'h01, 16'h8002);
      @(posedge clk_sys);
      ext_req_pin <= 3'h2;
      repeat (8) @(posedge clk_sys);
      rd_chk("ext_rise", 5'h02, 16'h0002, 16'h0000);
      @(posedge clk_sys);
      ext_req_pin <= 3'h0;
      repeat (8) @(posedge clk_sys);
      rd_chk("ext_fall", 5'h02, 16'h0002, 16'h0002);
      wr(5'h02, 16'h0000);
      $display("t_ext done");
   endtask
   task automatic t_trap;
      wr(5'h1f, 16'h0000);
      @(posedge clk_sys);
      trap_event <= 5'h01;
      @(posedge clk_sys);
      trap_event <= 5'h00;
      repeat (2) @(posedge clk_sys);
      chk("top", {15'h0, cpu_level_out[3]}, 16'h0001);
      wr(5'h1c, 16'h0000);
      rd_chk("core_ro", 5'h1c, 16'h0008, 16'h0008);
      rd_chk("trapflag", 5'h00, 16'h001f, 16'h0001);
      chk("masked", {15'h0, irq_out}, 16'h0000);
      wr(5'h1f, 16'h0001);
      chk("irq_on", {15'h0, irq_out}, 16'h0001);
      wr(5'h1e, 16'h0001);
      chk("irq_clr", {15'h0, irq_out}, 16'h0000);
      $display("t_trap done");
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      srst <= 1'b0;
      t_reset();
      t_flags();
      t_request();
      t_ext();
      t_trap();
      report_and_stop();
   end
endmodule
